// >>> inc/bwr_pkg.sv
// Constants and types for the buffer write/read command handler.
// Assumes one clock domain; command fields arrive already parsed from the command block.
// Operation
// - One 24576-byte buffer, byte addressed 0..0x5FFF
// - Write mode field: 000, 001, 010
// - Mode 000: drop header, store from zero
// - Mode 000: length >= size+4 is illegal
// - Zero write length: no data, good status
// - Mode 001: drop header, store from address
// - Mode 001: length > size-addr+4 is illegal
// - Mode 010: no header, store from address
// - Mode 010: length >= size-addr is illegal
// - Runs while not ready, media untouched
// - Read opcode 0x3C, modes 000 to 011
// - Read 000: header, then bytes from zero
// - Read overlength ends good, all bytes sent
// - Zero read length: no data, good status
package bwr_pkg;
  localparam int unsigned BWR_DEPTH     = 24576;
  localparam int          BWR_AW        = 15;
  localparam logic [7:0]  BWR_OP_WRITE  = 8'h3B;
  localparam logic [7:0]  BWR_OP_READ   = 8'h3C;
  localparam logic [2:0]  BWR_MODE_HDR  = 3'h0;
  localparam logic [2:0]  BWR_MODE_HADR = 3'h1;
  localparam logic [2:0]  BWR_MODE_DATA = 3'h2;
  localparam logic [2:0]  BWR_MODE_DESC = 3'h3;
  localparam logic [25:0] BWR_BUF_SIZE  = 26'h00_6000;
  localparam logic [25:0] BWR_HDR_LEN   = 26'h00_0004;
  localparam logic [2:0]  BWR_HDR_CNT   = 3'h4;
  localparam logic [7:0]  BWR_ADDR_BND  = 8'h00;

  typedef logic [7:0]  bwr_byte_t;
  typedef logic [23:0] bwr_field_t;

  typedef enum logic [2:0] {
    BWR_IDLE  = 3'b000,
    BWR_EVAL  = 3'b001,
    BWR_WRITE = 3'b010,
    BWR_READ  = 3'b011,
    BWR_DONE  = 3'b100
  } bwr_state_t;
endpackage : bwr_pkg

// >>> design/bwr_buf_ram.sv
// Byte-wide data buffer with one write and one registered read port.
// Assumes both ports share mclk; contents are not cleared by reset.
`timescale 1ns/10ps
module bwr_buf_ram #(
  parameter int DEPTH = 24576,
  parameter int AW    = 15
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : bwr_buf_ram

// >>> design/bwr_skid2.sv
// Two-entry buffer with valid/ready on both sides; output data is registered.
// Assumes the filler honours in_ready; the drainer may stall at will.
`timescale 1ns/10ps
module bwr_skid2 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [1:0]   cnt_reg;
  logic [W-1:0] tail_reg;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 2'd0;
    end else if (push && !pop) begin
      cnt_reg <= cnt_reg + 2'd1;
    end else if (pop && !push) begin
      cnt_reg <= cnt_reg - 2'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_data <= '0;
      tail_reg <= '0;
    end else begin
      if (pop) begin
        out_data <= (cnt_reg == 2'd2) ? tail_reg : in_data;
      end else if (push && cnt_reg == 2'd0) begin
        out_data <= in_data;
      end
      if (push && ((cnt_reg == 2'd1 && !pop) || cnt_reg == 2'd2)) begin
        tail_reg <= in_data;
      end
    end
  end

  // A stalled drainer must see the same word on the next cycle
  a_skid_stall_hold : assert property (@(posedge mclk) disable iff (rst)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("stalled word changed");
endmodule : bwr_skid2

// >>> design/bwr_cmd_ctrl.sv
// Buffer write/read command handler: checks lengths, moves bytes to and from the buffer.
// Assumes the command block arrives parsed, and data phases are byte streams
// with valid/ready toward the initiator's bus logic.
`timescale 1ns/10ps
module bwr_cmd_ctrl #(
  parameter int DEPTH = bwr_pkg::BWR_DEPTH,
  parameter int AW    = bwr_pkg::BWR_AW
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Command block
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire bwr_pkg::bwr_byte_t cmd_opcode,
  input  wire logic [2:0]         cmd_mode,
  input  wire bwr_pkg::bwr_field_t cmd_addr,
  input  wire bwr_pkg::bwr_field_t cmd_len,
  // Completion
  output logic                    cmd_done,
  output logic                    cmd_check,
  output logic                    cmd_illegal,
  // Phase indicators
  output logic                    data_out_phase,
  output logic                    data_in_phase,
  // Data from initiator
  input  wire logic               wr_valid,
  output logic                    wr_ready,
  input  wire bwr_pkg::bwr_byte_t wr_data,
  // Data to initiator
  output logic                    rd_valid,
  input  wire logic               rd_ready,
  output bwr_pkg::bwr_byte_t      rd_data
);
  import bwr_pkg::*;

  bwr_state_t    state_reg;
  bwr_state_t    state_next;
  bwr_byte_t     opc_reg;
  logic [2:0]    mode_reg;
  bwr_field_t    addr_reg;
  bwr_field_t    len_reg;
  logic [25:0]   cnt_reg;
  logic [2:0]    skip_reg;
  logic [2:0]    hdr_left_reg;
  logic [1:0]    hdr_idx_reg;
  logic [31:0]   hdr_word_reg;
  logic [AW-1:0] ptr_reg;
  logic          pend_reg;
  logic          check_reg;
  logic          illegal_reg;

  logic [25:0]   len_w;
  logic [25:0]   base;
  logic [25:0]   room;
  logic [25:0]   rd_total;
  logic [25:0]   rd_cnt;
  logic          addr_ok;
  logic          zero_len;
  logic          is_wr;
  logic          is_rd;
  logic          bad;
  logic          wr_take;
  logic          ram_we;
  logic          ram_re;
  logic          rd_issue;
  logic          hdr_now;
  logic          fifo_push;
  logic          fifo_ready;
  bwr_byte_t     fifo_din;
  bwr_byte_t     ram_q;

  function automatic bwr_byte_t hdr_byte(input logic [31:0] w, input logic [1:0] i);
    case (i)
      2'd0:    hdr_byte = w[31:24];
      2'd1:    hdr_byte = w[23:16];
      2'd2:    hdr_byte = w[15:8];
      default: hdr_byte = w[7:0];
    endcase
  endfunction : hdr_byte

  // Command evaluation
  always_comb begin
    len_w    = {2'b00, len_reg};
    base     = (mode_reg == BWR_MODE_HDR) ? 26'h00_0000 : {2'b00, addr_reg};
    addr_ok  = base < BWR_BUF_SIZE;
    room     = addr_ok ? BWR_BUF_SIZE - base : 26'h00_0000;
    zero_len = (len_w == 26'h00_0000);
    is_wr    = (opc_reg == BWR_OP_WRITE);
    is_rd    = (opc_reg == BWR_OP_READ);
    bad      = 1'b1;
    if (is_wr) begin
      case (mode_reg)
        BWR_MODE_HDR:  bad = len_w >= room + BWR_HDR_LEN;
        BWR_MODE_HADR: bad = !addr_ok || (len_w > room + BWR_HDR_LEN);
        BWR_MODE_DATA: bad = !addr_ok || (len_w >= room);
        default:       bad = 1'b1;
      endcase
    end else if (is_rd) begin
      case (mode_reg)
        BWR_MODE_HDR:  bad = 1'b0;
        BWR_MODE_HADR: bad = !addr_ok;
        BWR_MODE_DATA: bad = !addr_ok;
        BWR_MODE_DESC: bad = 1'b0;
        default:       bad = 1'b1;
      endcase
    end
    if (zero_len && (is_wr || is_rd) && mode_reg <= BWR_MODE_DESC) begin
      bad = 1'b0;
    end
    case (mode_reg)
      BWR_MODE_DATA: rd_total = room;
      BWR_MODE_DESC: rd_total = BWR_HDR_LEN;
      default:       rd_total = room + BWR_HDR_LEN;
    endcase
    rd_cnt = (len_w < rd_total) ? len_w : rd_total;
  end

  // Data movement strobes
  assign wr_take   = (state_reg == BWR_WRITE) && wr_valid;
  assign ram_we    = wr_take && (skip_reg == 3'd0);
  assign hdr_now   = (hdr_left_reg != 3'd0);
  assign rd_issue  = (state_reg == BWR_READ) && (cnt_reg != 26'h00_0000) && !pend_reg
                     && fifo_ready;
  assign ram_re    = rd_issue && !hdr_now;
  assign fifo_push = (rd_issue && hdr_now) || pend_reg;
  assign fifo_din  = pend_reg ? ram_q : hdr_byte(hdr_word_reg, hdr_idx_reg);

  // Ports
  assign cmd_ready      = (state_reg == BWR_IDLE);
  assign cmd_done       = (state_reg == BWR_DONE);
  assign cmd_check      = check_reg;
  assign cmd_illegal    = illegal_reg;
  assign wr_ready       = (state_reg == BWR_WRITE);
  assign data_out_phase = (state_reg == BWR_WRITE);
  assign data_in_phase  = (state_reg == BWR_READ);

  // Sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BWR_IDLE: begin
        if (cmd_valid) begin
          state_next = BWR_EVAL;
        end
      end
      BWR_EVAL: begin
        if (bad || zero_len) begin
          state_next = BWR_DONE;
        end else if (is_wr) begin
          state_next = BWR_WRITE;
        end else begin
          state_next = BWR_READ;
        end
      end
      BWR_WRITE: begin
        if (wr_take && cnt_reg == 26'h00_0001) begin
          state_next = BWR_DONE;
        end
      end
      BWR_READ: begin
        if (cnt_reg == 26'h00_0000 && !pend_reg && !rd_valid) begin
          state_next = BWR_DONE;
        end
      end
      BWR_DONE: state_next = BWR_IDLE;
      default:  state_next = BWR_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= BWR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Command capture; accepted whatever the drive readiness, media never touched
  always_ff @(posedge mclk) begin
    if (rst) begin
      opc_reg  <= 8'h00;
      mode_reg <= 3'h0;
      addr_reg <= 24'h00_0000;
      len_reg  <= 24'h00_0000;
    end else if (cmd_valid && cmd_ready) begin
      opc_reg  <= cmd_opcode;
      mode_reg <= cmd_mode;
      addr_reg <= cmd_addr;
      len_reg  <= cmd_len;
    end
  end

  // Completion status, held until the next command
  always_ff @(posedge mclk) begin
    if (rst) begin
      check_reg   <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (state_reg == BWR_EVAL) begin
      check_reg   <= bad;
      illegal_reg <= bad;
    end
  end

  // Transfer counters and header handling
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg      <= 26'h00_0000;
      skip_reg     <= 3'h0;
      hdr_left_reg <= 3'h0;
      hdr_idx_reg  <= 2'h0;
      hdr_word_reg <= 32'h0000_0000;
    end else if (state_reg == BWR_EVAL) begin
      cnt_reg      <= is_wr ? len_w : rd_cnt;
      skip_reg     <= (mode_reg == BWR_MODE_DATA) ? 3'h0 : BWR_HDR_CNT;
      hdr_left_reg <= (mode_reg == BWR_MODE_DATA) ? 3'h0 : BWR_HDR_CNT;
      hdr_idx_reg  <= 2'h0;
      hdr_word_reg <= (mode_reg == BWR_MODE_DESC) ? {BWR_ADDR_BND, BWR_BUF_SIZE[23:0]}
                                                  : {8'h00, room[23:0]};
    end else begin
      if (wr_take || rd_issue) begin
        cnt_reg <= cnt_reg - 26'h00_0001;
      end
      if (wr_take && skip_reg != 3'h0) begin
        skip_reg <= skip_reg - 3'h1;
      end
      if (rd_issue && hdr_now) begin
        hdr_left_reg <= hdr_left_reg - 3'h1;
        hdr_idx_reg  <= hdr_idx_reg + 2'h1;
      end
    end
  end

  // Buffer pointer and read pipeline
  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr_reg  <= '0;
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= ram_re;
      if (state_reg == BWR_EVAL) begin
        ptr_reg <= base[AW-1:0];
      end else if (ram_we || ram_re) begin
        ptr_reg <= ptr_reg + 1'b1;
      end
    end
  end

  bwr_buf_ram #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_ram (
    .mclk  (mclk),
    .rst   (rst),
    .we    (ram_we),
    .waddr (ptr_reg),
    .wdata (wr_data),
    .re    (ram_re),
    .raddr (ptr_reg),
    .rdata (ram_q)
  );

  bwr_skid2 #(
    .W (8)
  ) u_out_buf (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   (fifo_din),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_illegal_end;
    ##1 (state_reg == BWR_DONE && cmd_check && cmd_illegal);
  endsequence

  sequence s_good_end;
    ##1 (state_reg == BWR_DONE && !cmd_check) ##1 (state_reg == BWR_IDLE);
  endsequence

  a_zero_len_good : assert property (
    (state_reg == BWR_EVAL && zero_len && (is_wr || is_rd) && mode_reg <= BWR_MODE_DESC)
    |-> s_good_end) else $error("zero length did not end good");

  a_wr_hdr_limit : assert property (
    (state_reg == BWR_EVAL && is_wr && mode_reg == BWR_MODE_HDR && len_w >= 26'h00_6004)
    |-> s_illegal_end) else $error("mode 000 overlength not refused");

  a_wr_addr_limit : assert property (
    (state_reg == BWR_EVAL && is_wr && mode_reg == BWR_MODE_HADR && !zero_len
     && len_w > room + 26'h00_0004) |-> s_illegal_end) else $error("mode 001 limit missed");

  a_wr_data_limit : assert property (
    (state_reg == BWR_EVAL && is_wr && mode_reg == BWR_MODE_DATA && !zero_len
     && len_w >= room) |-> s_illegal_end) else $error("mode 010 limit missed");

  a_wr_hdr_skip : assert property (
    (ram_we && mode_reg != BWR_MODE_DATA)
    |-> ((len_w - cnt_reg >= BWR_HDR_LEN)
         && (26'(ptr_reg) == base + len_w - cnt_reg - BWR_HDR_LEN)))
    else $error("header byte stored");

  a_wr_seq_addr : assert property (
    ram_we |=> (ptr_reg == $past(ptr_reg) + 1'b1)) else $error("write pointer not advanced");

  a_rd_overlength : assert property (
    (state_reg == BWR_EVAL && is_rd && mode_reg == BWR_MODE_HDR && len_w > 26'h00_6004)
    |-> ##1 (state_reg == BWR_READ && cnt_reg == 26'h00_6004)) else $error("read length clip");

  a_rd_hdr_first : assert property (
    (state_reg == BWR_EVAL && is_rd && mode_reg == BWR_MODE_HDR && !zero_len)
    |-> ##1 (ptr_reg == '0 && hdr_left_reg == 3'h4 && hdr_word_reg == 32'h0000_6000))
    else $error("read mode 000 header wrong");

  a_rd_opcode : assert property (
    (state_reg == BWR_EVAL && opc_reg == 8'h3C && (mode_reg == 3'h0 || mode_reg == 3'h3))
    |-> ##1 !cmd_check) else $error("read command refused");
endmodule : bwr_cmd_ctrl

// >>> dv/bwr_init_model.sv
// Initiator model: sends queued bytes on the write stream, collects read bytes.
// Assumes the bench fills tx_q and empties rx_q; signals change at the falling edge.
`timescale 1ns/10ps
module bwr_init_model (
  // Clock
  input  wire logic                mclk,
  // Write stream
  output logic                     wr_valid,
  input  wire logic                wr_ready,
  output bwr_pkg::bwr_byte_t       wr_data,
  // Read stream
  input  wire logic                rd_valid,
  output logic                     rd_ready,
  input  wire bwr_pkg::bwr_byte_t  rd_data,
  // Stall control
  input  wire logic                slow
);
  import bwr_pkg::*;
  bwr_byte_t tx_q[$];
  bwr_byte_t rx_q[$];
  logic      wr_hit = 1'b0;
  int        cyc = 0;
  // The buffer identifier is not carried: it is always zero
  initial begin
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_ready = 1'b0;
  end
  // Bytes leave the queue at the edge that takes them, so the bench sees it settled
  always @(posedge mclk) begin
    wr_hit = wr_valid && wr_ready;
    if (wr_hit && tx_q.size() > 0) begin
      void'(tx_q.pop_front());
    end
    if (rd_valid && rd_ready) begin
      rx_q.push_back(rd_data);
    end
  end
  // Valid holds until taken; an idle data line shows the inverse of its last value
  always @(negedge mclk) begin
    cyc = cyc + 1;
    if (!(wr_valid && !wr_hit) || tx_q.size() == 0) begin
      wr_valid = tx_q.size() > 0 && !(slow && cyc % 3 == 0);
    end
    wr_data = wr_valid ? tx_q[0] : ~wr_data;
    rd_ready = !(slow && cyc % 3 != 0);
  end
endmodule : bwr_init_model

// >>> dv/bwr_cmd_ctrl_test.sv
// Bench for the buffer command handler: runs commands, checks status and data.
// Assumes the package is compiled first; the initiator model drives the streams.
`timescale 1ns/10ps
module bwr_cmd_ctrl_test;
  import bwr_pkg::*;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [7:0] cmd_opcode = 8'h00;
  logic [2:0] cmd_mode = 3'h0;
  bwr_field_t cmd_addr = 24'h00_0000;
  bwr_field_t cmd_len = 24'h00_0000;
  logic       slow = 1'b0;
  logic       cmd_ready, cmd_done, cmd_check, cmd_illegal;
  logic       data_out_phase, data_in_phase;
  logic       wr_valid, wr_ready, rd_valid, rd_ready;
  bwr_byte_t  wr_data, rd_data;
  int         err_total = 0;
  int         tests_run = 0;

  bwr_cmd_ctrl dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_mode(cmd_mode), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_done(cmd_done), .cmd_check(cmd_check), .cmd_illegal(cmd_illegal),
    .data_out_phase(data_out_phase), .data_in_phase(data_in_phase), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data));
  bwr_init_model m (.mclk(mclk), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .slow(slow));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("compares=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rx(input bwr_byte_t e[$]);
    chk(m.rx_q.size(), e.size());
    foreach (e[i]) begin
      if (i < m.rx_q.size()) begin
        chk(m.rx_q[i], e[i]);
      end
    end
  endtask : chk_rx

  // One command; waits for its end and checks status and whether a phase ran
  task automatic run(input logic [7:0] op, input logic [2:0] md, input bwr_field_t ad,
                     input bwr_field_t ln, input logic ck);
    int   n;
    logic ph;
    n = 0;
    ph = 1'b0;
    m.rx_q.delete();
    @(negedge mclk);
    chk(cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_mode = md;
    cmd_addr = ad;
    cmd_len = ln;
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && n < 60000) begin
      ph = ph | data_out_phase | data_in_phase;
      @(negedge mclk);
      n++;
    end
    if (n >= 60000) begin
      err_total++;
      end_sim;
    end
    chk(cmd_check, ck);
    chk(cmd_illegal, ck);
    chk(ph, !ck && ln != 0);
  endtask : run

  initial begin
    repeat (2) @(negedge mclk);
    chk({cmd_ready, cmd_done, cmd_check, rd_valid, wr_ready}, 5'h10);
    rst = 1'b0;
    for (int md = 0; md < 4; md++) begin
      if (md < 3) begin
        run(BWR_OP_WRITE, md[2:0], 24'h00_7000, 24'h00_0000, 1'b0);
      end
      run(BWR_OP_READ, md[2:0], 24'h00_7000, 24'h00_0000, 1'b0);
    end
    slow = 1'b1;
    m.tx_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA1, 8'hA2, 8'hA3};
    run(BWR_OP_WRITE, BWR_MODE_HDR, 24'h00_0100, 24'h00_0007, 1'b0);
    m.tx_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hB1, 8'hB2};
    run(BWR_OP_WRITE, BWR_MODE_HADR, 24'h00_5FFE, 24'h00_0006, 1'b0);
    chk(m.tx_q.size(), 0);
    m.tx_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hB1, 8'hB2, 8'hB3};
    run(BWR_OP_WRITE, BWR_MODE_HADR, 24'h00_5FFE, 24'h00_0007, 1'b1);
    run(BWR_OP_WRITE, BWR_MODE_DATA, 24'h00_5FFE, 24'h00_0002, 1'b1);
    run(BWR_OP_WRITE, BWR_MODE_HDR, 24'h00_0000, 24'h00_6004, 1'b1);
    run(BWR_OP_WRITE, BWR_MODE_DESC, 24'h00_0000, 24'h00_0004, 1'b1);
    chk(m.tx_q.size(), 7);
    m.tx_q = '{8'hC1, 8'hC2};
    run(BWR_OP_WRITE, BWR_MODE_DATA, 24'h00_0003, 24'h00_0002, 1'b0);
    run(BWR_OP_READ, BWR_MODE_HDR, 24'h00_0100, 24'h00_0009, 1'b0);
    chk_rx('{8'h00, 8'h00, 8'h60, 8'h00, 8'hA1, 8'hA2, 8'hA3, 8'hC1, 8'hC2});
    run(BWR_OP_READ, BWR_MODE_DATA, 24'h00_5FFE, 24'h00_0005, 1'b0);
    chk_rx('{8'hB1, 8'hB2});
    run(BWR_OP_READ, BWR_MODE_HADR, 24'h00_5FFE, 24'h00_0007, 1'b0);
    chk_rx('{8'h00, 8'h00, 8'h00, 8'h02, 8'hB1, 8'hB2});
    run(BWR_OP_READ, BWR_MODE_DESC, 24'h00_0000, 24'h00_0002, 1'b0);
    chk_rx('{8'h00, 8'h00});
    run(BWR_OP_READ, BWR_MODE_DESC, 24'h00_0000, 24'h00_0009, 1'b0);
    chk_rx('{8'h00, 8'h00, 8'h60, 8'h00});
    run(BWR_OP_READ, BWR_MODE_HADR, 24'h00_6000, 24'h00_0004, 1'b1);
    run(8'h3D, BWR_MODE_HDR, 24'h00_0000, 24'h00_0004, 1'b1);
    run(BWR_OP_READ, 3'h4, 24'h00_0000, 24'h00_0004, 1'b1);
    slow = 1'b0;
    run(BWR_OP_READ, BWR_MODE_HDR, 24'h00_0000, 24'hFF_FFFF, 1'b0);
    chk(m.rx_q.size(), 24580);
    chk({m.rx_q[0], m.rx_q[1], m.rx_q[2], m.rx_q[3]}, 32'h0000_6000);
    end_sim;
  end
endmodule : bwr_cmd_ctrl_test
